// File: include/ccg_consts.vh
`ifndef CCG_CONSTS_VH
`define CCG_CONSTS_VH

// clock source select codes, field sits in bits 7 to 5 of the latched config
`define CCG_SEL_MSB 7
`define CCG_SEL_LSB 5
`define CCG_SEL_X4 3'h7
`define CCG_SEL_X3 3'h6
`define CCG_SEL_X2 3'h5
`define CCG_SEL_X5 3'h4
`define CCG_SEL_DIRECT 3'h3
`define CCG_SEL_X1P5 3'h2
`define CCG_SEL_PRESCALE 3'h1
`define CCG_SEL_X2P5 3'h0

// multiplication factors held in halves, so 1.5 and 2.5 stay integral
`define CCG_HALF_X4 4'h8
`define CCG_HALF_X3 4'h6
`define CCG_HALF_X2 4'h4
`define CCG_HALF_X5 4'ha
`define CCG_HALF_X1P5 4'h3
`define CCG_HALF_X2P5 4'h5
`define CCG_HALF_NONE 4'h0

// reset value of the latched port configuration: all pins high, default x4
`define CCG_CFG_RESET 8'hff

// clock rate of ref_clk and the resulting cycle time
`define CCG_REF_CLK_HZ 20000000
`define CCG_REF_PERIOD_NS 50

// reset value of the oscillator period estimate, in ref_clk cycles; eight bits
// wide, the loop pads it up to its own counter width
`define CCG_EST_RESET 8'h20

`endif

// File: logic/ccg_pll.v
`timescale 1ns/1ps
`include "ccg_consts.vh"

module ccg_pll #(
    parameter CNT_W = 16
) (
    input wire ref_clk,
    input wire rst_n,
    input wire enable,
    input wire osc_rise,
    input wire [3:0] mult_half,
    output reg cpu_clk_pll,
    output reg locked
);

    localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    reg [CNT_W-1:0] period_cnt;
    reg [CNT_W-1:0] period_est;
    reg [CNT_W-1:0] phase_acc;
    reg [CNT_W:0] phase_sum;
    reg [CNT_W:0] phase_left;

    // measure the oscillator period in ref_clk cycles, saturating on a stopped input
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_cnt <= CNT_ONE;
        end else if (!enable || osc_rise) begin
            period_cnt <= CNT_ONE;
        end else if (period_cnt != CNT_MAX) begin
            period_cnt <= period_cnt + CNT_ONE;
        end
    end

    // estimate walks one step per input period, so the output rate never jumps
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_est <= {{(CNT_W-8){1'b0}}, `CCG_EST_RESET};
            locked <= 1'b0;
        end else if (enable && osc_rise) begin
            if (period_cnt > period_est) begin
                period_est <= period_est + CNT_ONE;
                locked <= 1'b0;
            end else if (period_cnt < period_est) begin
                period_est <= period_est - CNT_ONE;
                locked <= 1'b0;
            end else begin
                locked <= 1'b1;
            end
        end else if (!enable) begin
            locked <= 1'b0;
        end
    end

    // fractional toggle generator: 2F toggles per estimated period gives f_osc times F
    always @* begin
        phase_sum = {1'b0, phase_acc} + {{(CNT_W-3){1'b0}}, mult_half};
        phase_left = phase_sum - {1'b0, period_est};
    end

    // no resync on input rising edges; output phase free-runs and only its rate tracks the oscillator
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_acc <= {CNT_W{1'b0}};
            cpu_clk_pll <= 1'b0;
        end else if (!enable) begin
            phase_acc <= {CNT_W{1'b0}};
            cpu_clk_pll <= 1'b0;
        end else if (phase_sum >= {1'b0, period_est}) begin
            phase_acc <= phase_left[CNT_W-1:0];
            cpu_clk_pll <= ~cpu_clk_pll;
        end else begin
            phase_acc <= phase_sum[CNT_W-1:0];
        end
    end

endmodule // ccg_pll

// File: logic/ccg_clock_gen.v
// Contract
// - both cpu clock edges trigger work; a half period spans two consecutive edges.
// - mechanism chosen by three-bit field at bits 7 to 5 of latched config.
// - long hardware reset loads config from upper port pins; board holds select value.
// - select codes 111..000 give x4, x3, x2, x5, 1:1, x1.5, /2, x2.5.
// - select 001 divides the oscillator by two through a prescaler.
// - prescaler high and low phases each last one oscillator period.
// - multiplying settings enable the loop; cpu clock equals oscillator times factor.
// - loop resynchronises to the oscillator gradually, never an abrupt frequency change.
// - select 011 disables the loop and passes the oscillator straight through.
// - direct drive phases follow the oscillator's own high and low times.
// - in direct drive two consecutive half periods equal one oscillator period.
`timescale 1ns/1ps
`include "ccg_consts.vh"

module ccg_clock_gen #(
    parameter CNT_W = 16
) (
    input wire ref_clk,
    input wire reset_n,
    input wire osc_in,
    input wire long_reset,
    input wire [7:0] upper_port_byte,
    output reg cpu_clk,
    output reg clock_half_period,
    output wire [7:0] reset_latched_port_config,
    output wire [2:0] clock_source_select,
    output wire pll_enable,
    output wire pll_locked,
    output wire prescaler_mode,
    output wire direct_mode
);

    localparam [1:0] MODE_PLL = 2'h0;
    localparam [1:0] MODE_DIRECT = 2'h1;
    localparam [1:0] MODE_PRESCALE = 2'h2;

    // reset release
    reg [1:0] rst_sync;
    wire rst_n;

    // oscillator synchroniser and rising-edge detect
    reg osc_meta;
    reg osc_sync;
    reg osc_prev;
    wire osc_rise;

    // long reset and pin synchronisers, latched configuration
    reg lr_meta;
    reg lr_sync;
    reg [7:0] port_meta;
    reg [7:0] port_sync;
    reg [7:0] port_cfg;

    // decoded mechanism and multiplication factor
    reg [1:0] mode;
    reg [3:0] mult_half;

    // candidate clock sources and the selected next level
    reg prescale_clk;
    wire pll_clk;
    reg next_cpu_clk;

    // release the asynchronous reset through two flops so it leaves cleanly on ref_clk
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // oscillator pin crosses into ref_clk; the first flop is never looked at
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_meta <= osc_in;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end
    assign osc_rise = osc_sync & ~osc_prev;

    // long reset request and the port pins are asynchronous levels as well; a pin that
    // moves while sampled may settle either way, and only the second flop is latched
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lr_meta <= 1'b0;
            lr_sync <= 1'b0;
            port_meta <= `CCG_CFG_RESET;
            port_sync <= `CCG_CFG_RESET;
        end else begin
            lr_meta <= long_reset;
            lr_sync <= lr_meta;
            port_meta <= upper_port_byte;
            port_sync <= port_meta;
        end
    end

    // pin levels are followed for as long as long reset lasts; the last sample stays
    // latched afterwards, so the mechanism can never switch under a running cpu
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_cfg <= `CCG_CFG_RESET;
        end else if (lr_sync) begin
            port_cfg <= port_sync;
        end
    end
    assign reset_latched_port_config = port_cfg;
    assign clock_source_select = port_cfg[`CCG_SEL_MSB:`CCG_SEL_LSB];

    // decode the select field into a mechanism and a factor counted in halves;
    // every code that is neither direct nor prescale runs the loop, and 000 sits
    // in the default branch so any select value still yields a running clock
    always @* begin
        mode = MODE_PLL;
        mult_half = `CCG_HALF_NONE;
        case (clock_source_select)
            `CCG_SEL_X4: begin
                mult_half = `CCG_HALF_X4;
            end
            `CCG_SEL_X3: begin
                mult_half = `CCG_HALF_X3;
            end
            `CCG_SEL_X2: begin
                mult_half = `CCG_HALF_X2;
            end
            `CCG_SEL_X5: begin
                mult_half = `CCG_HALF_X5;
            end
            `CCG_SEL_DIRECT: begin
                mode = MODE_DIRECT;
            end
            `CCG_SEL_X1P5: begin
                mult_half = `CCG_HALF_X1P5;
            end
            `CCG_SEL_PRESCALE: begin
                mode = MODE_PRESCALE;
            end
            default: begin
                mult_half = `CCG_HALF_X2P5;
            end
        endcase
    end

    assign pll_enable = (mode == MODE_PLL);
    assign prescaler_mode = (mode == MODE_PRESCALE);
    assign direct_mode = (mode == MODE_DIRECT);

    // prescaler toggles on each input rising edge, so every phase is one full
    // input period whatever the input duty cycle
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_clk <= 1'b0;
        end else if (mode != MODE_PRESCALE) begin
            prescale_clk <= 1'b0;
        end else if (osc_rise) begin
            prescale_clk <= ~prescale_clk;
        end
    end

    // the loop only runs in multiplying settings; it idles low otherwise to save toggling
    ccg_pll #(
        .CNT_W(CNT_W)
    ) u_pll (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .enable(pll_enable),
        .osc_rise(osc_rise),
        .mult_half(mult_half),
        .cpu_clk_pll(pll_clk),
        .locked(pll_locked)
    );

    // select the cpu clock source; direct drive copies the synchronised input level,
    // so its high and low times are the input's and each pair sums to one period
    always @* begin
        case (mode)
            MODE_DIRECT: begin
                next_cpu_clk = osc_sync;
            end
            MODE_PRESCALE: begin
                next_cpu_clk = prescale_clk;
            end
            default: begin
                next_cpu_clk = pll_clk;
            end
        endcase
    end

    // output clock from a flop; the half-period strobe marks every edge, rising or
    // falling, in the cycle that shows the new level
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_clk <= 1'b0;
            clock_half_period <= 1'b0;
        end else begin
            cpu_clk <= next_cpu_clk;
            clock_half_period <= (next_cpu_clk != cpu_clk);
        end
    end

    // latency and limits, counted in ref_clk rising edges:
    // - direct drive shows an oscillator level three edges after the pin moves
    //   (two synchroniser flops plus the output flop), so phase lengths are kept
    //   but quantised to whole ref_clk cycles
    // - the prescaler flips four edges after an oscillator rising edge; the falling
    //   edge of the input is never used, which is what makes the duty cycle irrelevant
    // - the loop needs a few oscillator periods after a mode change or reset before
    //   its estimate matches the measured period; until then pll_locked stays low and
    //   the output rate walks towards its target one step per input period
    // - a mode change through long reset switches sources at once, so the cpu clock
    //   may show one shortened phase at the switch
    // - the period counter saturates, so an oscillator period longer than
    //   2^CNT_W - 1 ref_clk cycles reads as the maximum and the loop runs fast
    // - this is a sampled model; edges are quantised to ref_clk, so an input
    //   faster than a quarter of ref_clk cannot be followed faithfully

endmodule // ccg_clock_gen

// File: testbench/ccg_clock_gen_asserts.sv
`timescale 1ns/1ps
module ccg_clock_gen_asserts #(
    parameter CNT_W = 16
) (
    input wire ref_clk,
    input wire reset_n,
    input wire osc_in,
    input wire long_reset,
    input wire [7:0] upper_port_byte,
    input wire cpu_clk,
    input wire clock_half_period,
    input wire [7:0] reset_latched_port_config,
    input wire [2:0] clock_source_select,
    input wire pll_enable,
    input wire pll_locked,
    input wire prescaler_mode,
    input wire direct_mode
);
    reg [3:0] run = 4'h0;
    wire run_ok = (run == 4'hf);
    reg armed = 1'b0;
    // one edge passes before the reset check, so power-up unknowns are not judged
    always @(posedge ref_clk) armed <= 1'b1;
    // settle counter: synchronisers need a few edges after reset before outputs mean anything
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) run <= 4'h0;
        else if (!run_ok) run <= run + 4'h1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_load;
        (run_ok && long_reset && $stable(upper_port_byte)) [*6];
    endsequence
    sequence s_quiet;
        (!long_reset) [*6];
    endsequence
    a_reset_state: assert property (disable iff (1'b0) armed && !reset_n |-> !cpu_clk && !pll_locked
        && !clock_half_period && reset_latched_port_config == 8'hff) else $error("bad state in reset");
    a_strobe_edge: assert property (run_ok |-> clock_half_period == $changed(cpu_clk))
        else $error("strobe not on cpu clock edge");
    a_select_field: assert property (clock_source_select == reset_latched_port_config[7:5])
        else $error("select not from config bits");
    a_mode_decode: assert property (prescaler_mode == (clock_source_select == 3'h1)
        && direct_mode == (clock_source_select == 3'h3)
        && pll_enable == (clock_source_select != 3'h3 && clock_source_select != 3'h1))
        else $error("mode decode wrong");
    a_cfg_load: assert property (s_load |-> reset_latched_port_config == upper_port_byte)
        else $error("config did not load pins");
    a_cfg_frozen: assert property (s_quiet |-> $stable(reset_latched_port_config))
        else $error("config moved outside long reset");
    a_direct_follow: assert property (run_ok && direct_mode && $past(direct_mode, 3)
        |-> cpu_clk == $past(osc_in, 3)) else $error("direct clock not following oscillator");
    a_pre_toggle: assert property (run_ok && prescaler_mode && $past(prescaler_mode, 6) && $rose(osc_in)
        |-> ##[3:5] $changed(cpu_clk)) else $error("prescaler missed a toggle");
endmodule // ccg_clock_gen_asserts

bind ccg_clock_gen ccg_clock_gen_asserts #(.CNT_W(CNT_W)) u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .osc_in(osc_in), .long_reset(long_reset), .upper_port_byte(upper_port_byte), .cpu_clk(cpu_clk),
    .clock_half_period(clock_half_period), .reset_latched_port_config(reset_latched_port_config),
    .clock_source_select(clock_source_select), .pll_enable(pll_enable), .pll_locked(pll_locked),
    .prescaler_mode(prescaler_mode), .direct_mode(direct_mode));

// File: testbench/ccg_osc_model.sv
`timescale 1ns/1ps
module ccg_osc_model (
    input wire ref_clk,
    input wire run,
    input wire [7:0] high_len,
    input wire [7:0] low_len,
    output reg osc
);
    reg [7:0] cnt = 8'h00;
    initial osc = 1'b0;
    // stands low while stopped, so no stale edge leaks into the next run
    always @(negedge ref_clk) begin
        if (!run) begin
            osc <= 1'b0;
            cnt <= 8'h00;
        end else if (cnt + 8'h01 >= (osc ? high_len : low_len)) begin
            osc <= ~osc;
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // ccg_osc_model

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct {logic [2:0] sel; logic [4:0] low; int cnt; int tol; int hl; logic lk;} ccg_note_t;
    reg ref_clk = 1'b0;
    reg reset_n = 1'b0;
    reg long_reset = 1'b0;
    reg [7:0] upper_port_byte = 8'h00;
    reg win = 1'b0;
    reg win_d = 1'b0;
    reg prev_cpu = 1'b0;
    reg [7:0] lfsr_state = 8'h35;
    wire osc_in, cpu_clk, clock_half_period, pll_enable, pll_locked, prescaler_mode, direct_mode;
    wire [7:0] reset_latched_port_config;
    wire [2:0] clock_source_select;
    int bad_count = 0;
    int comparisons = 0;
    int chg = 0;
    int hi_run = 0;
    int hi_len = 0;
    // cpu clock changes expected over eight oscillator periods, by select code
    int exp_cnt[8] = '{40, 8, 24, 16, 80, 32, 48, 64};
    ccg_note_t exp_q[$];
    ccg_note_t note;
    ccg_note_t plan;

    initial forever #25 ref_clk = ~ref_clk;

    function automatic [7:0] lfsr_next(input [7:0] s);
        lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task end_of_test;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // 15 high, 25 low: uneven duty so phase lengths show whose timing they follow
    ccg_osc_model u_osc (.ref_clk(ref_clk), .run(reset_n), .high_len(8'h0f), .low_len(8'h19), .osc(osc_in));

    ccg_clock_gen #(.CNT_W(8)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .osc_in(osc_in),
        .long_reset(long_reset), .upper_port_byte(upper_port_byte), .cpu_clk(cpu_clk),
        .clock_half_period(clock_half_period), .reset_latched_port_config(reset_latched_port_config),
        .clock_source_select(clock_source_select), .pll_enable(pll_enable), .pll_locked(pll_locked),
        .prescaler_mode(prescaler_mode), .direct_mode(direct_mode));

    // monitor: measures edges and high phase, compares against the oldest note when a window closes
    always @(posedge ref_clk) begin
        prev_cpu <= cpu_clk;
        win_d <= win;
        if (cpu_clk && !prev_cpu) hi_run <= 1;
        else if (cpu_clk) hi_run <= hi_run + 1;
        if (!cpu_clk && prev_cpu) hi_len <= hi_run;
        if (win) chg <= chg + (cpu_clk !== prev_cpu);
        if (win_d && !win) begin
            note = exp_q.pop_front();
            chg <= 0;
            check(clock_source_select, note.sel);
            check(reset_latched_port_config[4:0], note.low);
            check(chg >= note.cnt - note.tol && chg <= note.cnt + note.tol, 1'b1);
            check(pll_locked, note.lk);
            check(pll_enable, note.lk);
            if (note.hl != 0) check(hi_len[15:0], note.hl[15:0]);
        end
    end

    // driver: every select code through a long reset, then a refused pin change
    initial begin
        repeat (4) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        for (int code = 0; code < 8; code++) begin
            lfsr_state = lfsr_next(lfsr_state);
            upper_port_byte = {code[2:0], lfsr_state[4:0]};
            plan.sel = code[2:0];
            plan.low = lfsr_state[4:0];
            plan.cnt = exp_cnt[code];
            plan.tol = (code == 1 || code == 3) ? 0 : 2;
            plan.hl = (code == 3) ? 15 : (code == 1) ? 40 : 0;
            plan.lk = (code != 1 && code != 3);
            long_reset = 1'b1;
            repeat (12) @(negedge ref_clk);
            long_reset = 1'b0;
            repeat (6) @(negedge ref_clk);
            lfsr_state = lfsr_next(lfsr_state);
            upper_port_byte = lfsr_state;
            repeat (1200) @(negedge ref_clk);
            exp_q.push_back(plan);
            win = 1'b1;
            repeat (320) @(negedge ref_clk);
            win = 1'b0;
            repeat (4) @(negedge ref_clk);
        end
        end_of_test();
    end

    // about 12k cycles are needed; give twice that
    initial begin
        #1200000;
        bad_count++;
        end_of_test();
    end
endmodule // tb
